/* core/stream_sink.sv */
// streaming sink controller: accept-delay backpressure, buffer, packet checks
`timescale 1ns/1ps
`include "stream_sink_regs.svh"


// ----------------------------------------------------------------
// buffer
// ----------------------------------------------------------------
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] count_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready_out = (count != CW'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign count_out = count;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= CW'(count + 1'b1);
        end else if (pop && !push) begin
            count <= CW'(count - 1'b1);
        end
    end
endmodule

// ----------------------------------------------------------------
// sink top
// ----------------------------------------------------------------
module stream_sink (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // link from the source
    input wire logic src_valid_in,
    input wire stream_sink_pkg::beat_t src_beat_in,
    output logic snk_ready_out,
    // user side
    output logic user_valid_out,
    input wire logic user_ready_in,
    output stream_sink_pkg::beat_t user_beat_out,
    // packet status
    output logic framing_fault_out,
    input wire logic clear_fault_in
);
    localparam int L = `ACCEPT_DELAY_CYCLES;
    localparam int DEPTH = `FIFO_DEPTH;
    localparam int LW = (L > 0) ? L : 1;
    localparam int CW = $clog2(DEPTH+1);
    localparam int BW = $bits(stream_sink_pkg::beat_t);
    localparam int LANES = `HIGHEST_LANE_NUMBER + 1;

    logic [LW-1:0] pend;
    logic ready_cycle;
    logic take;
    logic [4:0] inflight;
    logic [CW-1:0] fifo_count;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [BW-1:0] fifo_out_data;
    stream_sink_pkg::beat_t captured;
    logic [LANES-1:0] open_pkt;
    logic bad_frame;

    function automatic logic [4:0] ones(input logic [LW-1:0] v);
        ones = '0;
        for (int i = 0; i < LW; i++) begin
            ones = 5'(ones + {4'h0, v[i]});
        end
    endfunction

    // ------------------------------------------------------------
    // accept-delay bookkeeping
    // ------------------------------------------------------------
    // every ready raised reserves one slot until its ready cycle has
    // passed; pops are not credited early, trading throughput for a
    // simple proof that no accepted beat can ever meet a full buffer
    assign inflight = (L == 0) ? 5'h00 : ones(pend);
    assign snk_ready_out = rstn_in &&
        ((5'(fifo_count) + inflight) < 5'(DEPTH));

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pend <= '0;
        end else begin
            pend <= LW'({pend, snk_ready_out});
        end
    end

    // delay zero: the cycle with ready high is the ready cycle itself
    assign ready_cycle = (L == 0) ? snk_ready_out : pend[LW-1];

    // link inputs come straight from source flops, so no second register here
    assign take = ready_cycle && src_valid_in && fifo_in_ready;

    always_comb begin
        captured = src_beat_in;
        if (!src_beat_in.last) begin
            captured.empty = '0;
        end
    end

    // ------------------------------------------------------------
    // per-lane packet framing
    // ------------------------------------------------------------
    // lanes interleave freely, so each lane keeps its own open flag
    assign bad_frame = take && (src_beat_in.first == open_pkt[src_beat_in.channel]);

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            open_pkt <= '0;
        end else if (take) begin
            open_pkt[src_beat_in.channel] <= !src_beat_in.last;
        end
    end

    // a new fault in the clearing cycle wins over the clear
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            framing_fault_out <= 1'b0;
        end else if (bad_frame) begin
            framing_fault_out <= 1'b1;
        end else if (clear_fault_in) begin
            framing_fault_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // buffer and user output stage
    // ------------------------------------------------------------
    stream_fifo #(
        .WIDTH(BW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .in_valid_in(take),
        .in_ready_out(fifo_in_ready),
        .in_data_in(captured),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data),
        .count_out(fifo_count)
    );

    assign fifo_out_ready = !user_valid_out || user_ready_in;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            user_valid_out <= 1'b0;
        end else if (fifo_out_ready) begin
            user_valid_out <= fifo_out_valid;
        end
    end

    // beat layout kept as received: symbol 0 stays in the top byte
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            user_beat_out <= '0;
        end else if (fifo_out_ready && fifo_out_valid) begin
            user_beat_out <= fifo_out_data;
        end
    end
endmodule

/* core/stream_sink_pkg.sv */
// types shared by the streaming sink, its monitor, its source model and its bench
`include "stream_sink_regs.svh"

package stream_sink_pkg;

    // one beat as it crosses the link; symbol 0 sits in the top bits
    typedef struct packed {
        logic [`DATA_BITS-1:0] data;
        logic [`CHANNEL_BITS-1:0] channel;
        logic [`FAULT_BITS-1:0] fault;
        logic first;
        logic last;
        logic [`EMPTY_BITS-1:0] empty;
    } beat_t;

endpackage

/* core/stream_sink_regs.svh */
// constants of the streaming sink: field widths, accept delay, buffer depth
`ifndef STREAM_SINK_REGS_SVH
`define STREAM_SINK_REGS_SVH

// ----------------------------------------------------------------
// beat field widths
// ----------------------------------------------------------------
`define SYMBOL_BITS 8
`define SYMBOLS_PER_BEAT 4
`define DATA_BITS 32
`define CHANNEL_BITS 8
`define FAULT_BITS 8
`define EMPTY_BITS 2
`define HIGHEST_LANE_NUMBER 255

// ----------------------------------------------------------------
// timing and buffering
// ----------------------------------------------------------------
`define ACCEPT_DELAY_CYCLES 2
`define FIFO_DEPTH 4

`endif

/* sim/stream_sink_monitor.sv */
// port checker of the streaming sink, bound to its top
`timescale 1ns/1ps
module stream_sink_monitor (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // link and user side
    input wire logic src_valid_in,
    input wire stream_sink_pkg::beat_t src_beat_in,
    input wire logic snk_ready_out,
    input wire logic user_valid_out,
    input wire logic user_ready_in,
    input wire stream_sink_pkg::beat_t user_beat_out,
    input wire logic framing_fault_out,
    input wire logic clear_fault_in
);
    logic [1:0] pend;
    logic [3:0] held;
    logic take;
    // a beat counts only in a ready cycle, two cycles after ready
    assign take = src_valid_in && pend[1];
    always_ff @(posedge mclk_in) begin
        pend <= rstn_in ? {pend[0], snk_ready_out} : 2'h0;
    end
    always_ff @(posedge mclk_in) begin
        held <= !rstn_in ? 4'h0 : held + 4'(take) - 4'(user_valid_out && user_ready_in);
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    AST_READY_UP: assert property ($rose(rstn_in) |-> snk_ready_out)
        else $error("ready low after reset");
    AST_RESET_CLEAN: assert property ($rose(rstn_in) |-> !user_valid_out && !framing_fault_out)
        else $error("outputs busy after reset");
    AST_CAPTURE_LAT: assert property ($rose(user_valid_out) |-> $past(take, 2))
        else $error("beat shown without a take");
    AST_USER_HOLD: assert property (user_valid_out && !user_ready_in |=> user_valid_out && $stable(user_beat_out))
        else $error("user beat moved");
    AST_EMPTY_ZERO: assert property (user_valid_out && !user_beat_out.last |-> user_beat_out.empty == 2'h0)
        else $error("empty not cleared");
    AST_HELD_CAP: assert property (held <= 4'h5)
        else $error("overrun");
    AST_READY_FULL: assert property (held == 4'h5 |-> !snk_ready_out)
        else $error("ready while full");
    AST_FAULT_STICKY: assert property (framing_fault_out && !clear_fault_in |=> framing_fault_out)
        else $error("fault dropped");
    AST_FAULT_CAUSE: assert property ($rose(framing_fault_out) |-> $past(take))
        else $error("fault without beat");
endmodule

bind stream_sink stream_sink_monitor mon (.mclk_in, .rstn_in, .src_valid_in, .src_beat_in,
    .snk_ready_out, .user_valid_out, .user_ready_in, .user_beat_out, .framing_fault_out,
    .clear_fault_in);

/* sim/stream_source_model.sv */
// source model: registered beats, sent only in ready cycles
`timescale 1ns/1ps
module stream_source_model (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic hold_in,
    input wire logic ready_in,
    output logic valid_out,
    output stream_sink_pkg::beat_t beat_out
);
    stream_sink_pkg::beat_t q[$];
    logic [1:0] pend;
    always_ff @(posedge mclk_in) begin
        pend <= rstn_in ? {pend[0], ready_in} : 2'h0;
        if (!rstn_in) begin
            valid_out <= 1'b0;
            beat_out <= '0;
        end else if (pend[0] && !hold_in && q.size() > 0) begin
            valid_out <= 1'b1;
            beat_out <= q.pop_front();
        end else begin
            valid_out <= 1'b0;
            // idle fields wander so the sink cannot lean on stale values
            beat_out <= ~beat_out;
        end
    end
endmodule

/* sim/tb_top.sv */
// self-checking bench of the streaming sink
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin $display("ERROR %0t %h %h", $time, a, b); err_total++; end end
module tb_top;
    logic mclk_in = 1'b0, rstn_in = 1'b0, user_ready_in = 1'b0, clear_fault_in = 1'b0, hold = 1'b0;
    logic src_valid_in, snk_ready_out, user_valid_out, framing_fault_out;
    stream_sink_pkg::beat_t src_beat_in, user_beat_out, e;
    stream_sink_pkg::beat_t exp_q[$];
    int err_total = 0;
    int checks = 0;
    stream_sink DUT (.mclk_in, .rstn_in, .src_valid_in, .src_beat_in, .snk_ready_out,
        .user_valid_out, .user_ready_in, .user_beat_out, .framing_fault_out, .clear_fault_in);
    stream_source_model src (.mclk_in, .rstn_in, .hold_in(hold), .ready_in(snk_ready_out),
        .valid_out(src_valid_in), .beat_out(src_beat_in));
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic wrap_up();
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // fault mask reuses the low data byte so every field varies
    function automatic stream_sink_pkg::beat_t mk(input logic [31:0] d, input logic [7:0] c,
        input logic fi, input logic la, input logic [1:0] em);
        return '{d, c, d[7:0], fi, la, em};
    endfunction
    task automatic tx(input stream_sink_pkg::beat_t b);
        src.q.push_back(b);
        if (!b.last) b.empty = 2'h0;
        exp_q.push_back(b);
    endtask
    task automatic rx();
        int n;
        n = 0;
        @(negedge mclk_in);
        while (user_valid_out !== 1'b1 && n < 60) begin
            @(negedge mclk_in);
            n++;
        end
        `CHK(user_valid_out, 1'b1)
        e = exp_q.pop_front();
        `CHK(user_beat_out, e)
        user_ready_in = 1'b1;
        @(negedge mclk_in);
        user_ready_in = 1'b0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(negedge mclk_in);
        rstn_in = 1'b1;
        @(negedge mclk_in);
        `CHK(snk_ready_out, 1'b1)
        tx(mk(32'h11223344, 8'h03, 1'b1, 1'b0, 2'h3));
        tx(mk(32'hA0B1C2D3, 8'h04, 1'b1, 1'b0, 2'h1));
        tx(mk(32'h55667788, 8'h03, 1'b0, 1'b1, 2'h1));
        tx(mk(32'h99AABBCC, 8'h04, 1'b0, 1'b1, 2'h0));
        repeat (4) rx();
        `CHK(framing_fault_out, 1'b0)
        hold = 1'b1;
        for (int i = 0; i < 6; i++) tx(mk(32'hF0000000 + i, 8'h01, i == 0, i == 5, 2'h2));
        repeat (3) @(negedge mclk_in);
        hold = 1'b0;
        repeat (20) @(negedge mclk_in);
        `CHK(snk_ready_out, 1'b0)
        repeat (6) rx();
        tx(mk(32'h0000BEEF, 8'h02, 1'b0, 1'b0, 2'h0));
        rx();
        `CHK(framing_fault_out, 1'b1)
        clear_fault_in = 1'b1;
        @(negedge mclk_in);
        clear_fault_in = 1'b0;
        `CHK(framing_fault_out, 1'b0)
        tx(mk(32'h0000CAFE, 8'h02, 1'b1, 1'b1, 2'h1));
        rx();
        `CHK(framing_fault_out, 1'b1)
        `CHK(user_valid_out, 1'b0)
        wrap_up();
    end
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
endmodule
